// *** rtl/video_conversion_map.svh ***
// Register offsets, field positions, reset values and limits of the engine
`ifndef VIDEO_CONVERSION_MAP_SVH
`define VIDEO_CONVERSION_MAP_SVH
`define VC_CTRL 12'h000
`define VC_STATUS 12'h004
`define VC_SRC_ADDR 12'h008
`define VC_DST_ADDR 12'h00C
`define VC_BMP_ADDR 12'h010
`define VC_SRC_SIZE 12'h014
`define VC_OUT_SIZE 12'h018
`define VC_HRATIO 12'h01C
`define VC_VRATIO 12'h020
`define VC_PAD 12'h024
`define VC_STRIDE 12'h028
`define VC_PALETTE 12'h02C
`define VC_CTRL_START 0
`define VC_CTRL_MODE_LO 1
`define VC_CTRL_ILACE 3
`define VC_CTRL_FIELD 4
`define VC_CTRL_CHROMA 5
`define VC_CTRL_UP 6
`define VC_ST_BUSY 0
`define VC_ST_DONE 1
`define VC_N_MIN 12'h100
`define VC_N_MAX 12'h800
`define VC_RATIO_RST 32'h0000_0100
`define VC_FIFO_DEPTH 8
`endif

// *** rtl/video_conversion_pkg.sv ***
// Types shared by the video conversion engine
package video_conversion_pkg;
  typedef enum logic [1:0] {
    MODE_SCALE, MODE_CHROMA, MODE_OVERLAY, MODE_PAD
  } mode_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ROW, ST_DISP, ST_BMP, ST_RD, ST_PROC, ST_DRAIN
  } state_type;
endpackage : video_conversion_pkg

// *** rtl/video_conversion_engine.sv ***
// Video conversion engine: APB registers, picture sequencer, output FIFO
// Operation
// RQ1: Scale step N clamped to 256..2048
// RQ2: Horizontal and vertical N set separately
// RQ3: Seven-tap anti-alias filter on luma only
// RQ4: Four-point interpolator shared by luma, chroma
// RQ5: Output line clipped to programmed width
// RQ6: Interlaced scaling reads lines of one field
// RQ7: Chroma lines converted 4:2:2 to/from 4:2:0
// RQ8: Two-bit bitmap blended over video
// RQ9: Video and bitmap read, one picture written
// RQ10: Edge pixels replicated outward by pad widths
// RQ11: Padding has progressive and interlaced methods
// RQ12: Progressive scaling reads consecutive frame lines
// RQ13: Program first, done after last write
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "video_conversion_map.svh"

module pixel_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `VC_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr;
  logic [AW:0] count;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  assign inReady = count != DEPTH[AW:0];
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (push) mem[wrPtr] <= inData;
  end
endmodule : pixel_fifo

module video_conversion_engine
  import video_conversion_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rdReq,
  output logic [31:0] rdAddr,
  input wire logic rdAck,
  input wire logic [31:0] rdData,
  output logic wrReq,
  output logic [31:0] wrAddr,
  output logic [31:0] wrData,
  input wire logic wrAck
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [6:1] ctrl;
  logic [31:0] srcBase, dstBase, bmpBase, srcSize, outSize;
  logic [31:0] hRatio, vRatio, padSize, stride, palette;
  logic done;
  state_type state;

  function automatic logic [11:0] clampStep(input logic [31:0] n);
    return (n[11:0] < `VC_N_MIN || n[31:12] != '0) ?
      ((n[31:12] != '0) ? `VC_N_MAX : `VC_N_MIN) :
      (n[11:0] > `VC_N_MAX) ? `VC_N_MAX : n[11:0];
  endfunction : clampStep

  function automatic logic [11:0] clampIdx(input logic signed [13:0] s,
      input logic [11:0] lim, input logic ilace);
    if (s < 0) return ilace ? {11'h000, s[0]} : 12'h000;
    if (s >= $signed({2'b00, lim}))
      return ilace ? lim - 12'h002 + {11'h000, s[0]} : lim - 12'h001;
    return s[11:0];
  endfunction : clampIdx

  wire apbDone = psel & penable & pready;
  wire apbWr = apbDone & pwrite;
  wire hitCtrl = paddr == `VC_CTRL;
  wire hitStat = paddr == `VC_STATUS;
  wire hitAny = hitCtrl | hitStat | paddr == `VC_SRC_ADDR |
    paddr == `VC_DST_ADDR | paddr == `VC_BMP_ADDR |
    paddr == `VC_SRC_SIZE | paddr == `VC_OUT_SIZE |
    paddr == `VC_HRATIO | paddr == `VC_VRATIO | paddr == `VC_PAD |
    paddr == `VC_STRIDE | paddr == `VC_PALETTE;
  wire [31:0] statusWord = {30'h0, done, state != ST_IDLE};
  wire [31:0] readMux =
    hitCtrl ? {25'h0, ctrl, 1'b0} : hitStat ? statusWord :
    paddr == `VC_SRC_ADDR ? srcBase : paddr == `VC_DST_ADDR ? dstBase :
    paddr == `VC_BMP_ADDR ? bmpBase : paddr == `VC_SRC_SIZE ? srcSize :
    paddr == `VC_OUT_SIZE ? outSize : paddr == `VC_HRATIO ? hRatio :
    paddr == `VC_VRATIO ? vRatio : paddr == `VC_PAD ? padSize :
    paddr == `VC_STRIDE ? stride : paddr == `VC_PALETTE ? palette : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      // Two-cycle access: one wait state keeps prdata a flop output
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hitAny;
      prdata <= (psel & ~pwrite & hitAny) ? readMux : 32'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '0;
      {srcBase, dstBase, bmpBase, srcSize, outSize} <= '0;
      hRatio <= `VC_RATIO_RST;
      vRatio <= `VC_RATIO_RST;
      {padSize, stride, palette} <= '0;
    end else if (apbWr) begin
      case (paddr)
        `VC_CTRL: ctrl <= pwdata[6:1];
        `VC_SRC_ADDR: srcBase <= pwdata;
        `VC_DST_ADDR: dstBase <= pwdata;
        `VC_BMP_ADDR: bmpBase <= pwdata;
        `VC_SRC_SIZE: srcSize <= pwdata;
        `VC_OUT_SIZE: outSize <= pwdata;
        `VC_HRATIO: hRatio <= {20'h0, clampStep(pwdata)}; // RQ1 RQ2
        `VC_VRATIO: vRatio <= {20'h0, clampStep(pwdata)}; // RQ1 RQ2
        `VC_PAD: padSize <= pwdata;
        `VC_STRIDE: stride <= pwdata;
        `VC_PALETTE: palette <= pwdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Geometry and addressing
  // ----------------------------------------------------------------
  mode_type mode;
  assign mode = mode_type'(ctrl[`VC_CTRL_MODE_LO+1:`VC_CTRL_MODE_LO]);
  wire isScale = mode == MODE_SCALE;
  wire ilace = ctrl[`VC_CTRL_ILACE];
  wire [11:0] srcW = srcSize[11:0];
  wire [11:0] srcH = srcSize[27:16];
  wire [11:0] outW = outSize[11:0];
  wire [11:0] outH = outSize[27:16];
  wire [11:0] hStep = clampStep(hRatio); // RQ1
  wire [11:0] vStep = clampStep(vRatio); // RQ1
  logic [11:0] row, col, outCnt;
  logic [19:0] hAcc, vAcc;
  logic [7:0] win [7];
  logic [7:0] g [4];
  logic [31:0] bmpWord;
  wire [11:0] vIdx = vAcc[19:8];
  wire [11:0] hPos = hAcc[19:8];
  wire [7:0] hFrac = hAcc[7:0];
  wire [11:0] padLine = clampIdx($signed({2'b00, row}) -
    $signed({6'h00, padSize[23:16]}), srcH, ilace); // RQ10 RQ11
  wire [11:0] padCol = clampIdx($signed({2'b00, outCnt}) -
    $signed({6'h00, padSize[7:0]}), srcW, 1'b0); // RQ10
  wire [11:0] logLine = isScale ? vIdx :
    mode == MODE_CHROMA ? (ctrl[`VC_CTRL_UP] ? row >> 1 : row << 1) : // RQ7
    mode == MODE_PAD ? padLine : row;
  // Field pictures sit interleaved in the frame buffer
  wire [11:0] physLine = (isScale && ilace) ?
    {logLine[10:0], ctrl[`VC_CTRL_FIELD]} : logLine; // RQ6 RQ12
  wire [11:0] srcX = isScale ? col : mode == MODE_PAD ? padCol : outCnt;
  wire [31:0] pixAddr = srcBase + 32'(physLine * stride[15:0]) +
    {18'h0, srcX, 2'b00};
  wire [11:0] bmpWords = (outW + 12'h00F) >> 4;
  wire [31:0] bmpAddr = bmpBase +
    {6'h0, 24'(row * bmpWords) + {12'h0, outCnt >> 4}, 2'b00};

  // ----------------------------------------------------------------
  // Filter, interpolator and overlay blend
  // ----------------------------------------------------------------
  wire [11:0] aaSum = {4'h0, win[0]} + {3'h0, win[1], 1'b0} +
    12'(3 * win[2]) + {2'h0, win[3], 2'b00} + 12'(3 * win[4]) +
    {3'h0, win[5], 1'b0} + {4'h0, win[6]};
  wire [7:0] aaOut = ctrl[`VC_CTRL_CHROMA] ? win[3] : aaSum[11:4]; // RQ3
  wire [15:0] fracProd = hFrac * (9'h100 - {1'b0, hFrac});
  wire signed [10:0] q = $signed({5'h00, fracProd[15:10]});
  wire signed [10:0] wMid = $signed(11'h100 - {3'h0, hFrac}) + q;
  wire signed [10:0] wNear = $signed({3'h0, hFrac}) + q;
  wire signed [21:0] ipSum = wMid * $signed({3'h0, g[2]}) +
    wNear * $signed({3'h0, g[1]}) -
    q * $signed({3'h0, g[3]}) - q * $signed({3'h0, g[0]}); // RQ4
  wire [7:0] ipOut = ipSum < 0 ? 8'h00 :
    (ipSum[21:8] > 14'h00FF) ? 8'hFF : ipSum[15:8];
  wire [1:0] code = 2'(bmpWord >> {outCnt[3:0], 1'b0});
  wire [8:0] mix = {1'b0, win[0]} +
    {1'b0, code == 2'h1 ? palette[7:0] : palette[15:8]};
  wire [7:0] ovlOut = code == 2'h0 ? win[0] :
    code == 2'h3 ? palette[23:16] : mix[8:1]; // RQ8
  wire [7:0] pixOut = isScale ? ipOut :
    mode == MODE_OVERLAY ? ovlOut : win[0];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic fifoInReady, fifoOutValid;
  logic [31:0] fifoOut;
  wire emit = isScale ? (col == hPos + 12'h007 && outCnt < outW) : 1'b1;
  wire push = state == ST_PROC && emit && fifoInReady;
  wire lineEnd = outCnt >= outW || (isScale && col >= srcW); // RQ5
  wire picEnd = row >= outH || (isScale && vIdx >= srcH);
  wire start = apbWr && hitCtrl && pwdata[`VC_CTRL_START];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      {row, col, outCnt, hAcc, vAcc} <= '0;
      rdReq <= 1'b0;
      rdAddr <= 32'h0;
      bmpWord <= 32'h0;
      done <= 1'b0;
      win <= '{default: 8'h00};
      g <= '{default: 8'h00};
    end else begin
      // Completion set wins over a same-cycle clear
      if (state == ST_DRAIN && !fifoOutValid && !wrReq) done <= 1'b1;
      else if (apbWr && hitStat && pwdata[`VC_ST_DONE]) done <= 1'b0;
      case (state)
        ST_IDLE: if (start) begin // RQ13
          state <= ST_ROW;
          {row, col, outCnt, hAcc, vAcc} <= '0;
        end
        ST_ROW: state <= picEnd ? ST_DRAIN : ST_DISP;
        ST_DISP: if (lineEnd) begin
          state <= ST_ROW;
          row <= row + 12'h001;
          vAcc <= vAcc + {8'h00, vStep};
          {col, outCnt, hAcc} <= '0;
        end else begin
          rdReq <= 1'b1;
          if (mode == MODE_OVERLAY && outCnt[3:0] == 4'h0) begin // RQ9
            state <= ST_BMP;
            rdAddr <= bmpAddr;
          end else begin
            state <= ST_RD;
            rdAddr <= pixAddr;
          end
        end
        ST_BMP: if (rdAck) begin // RQ9
          bmpWord <= rdData;
          rdAddr <= pixAddr;
          state <= ST_RD;
        end
        ST_RD: if (rdAck) begin
          rdReq <= 1'b0;
          win <= {rdData[7:0], win[0:5]};
          g <= {aaOut, g[0:2]};
          col <= col + 12'h001;
          state <= ST_PROC;
        end
        ST_PROC: if (!emit || fifoInReady) begin
          state <= ST_DISP;
          if (emit) begin
            outCnt <= outCnt + 12'h001;
            hAcc <= hAcc + {8'h00, hStep};
          end
        end
        ST_DRAIN: if (!fifoOutValid && !wrReq) state <= ST_IDLE; // RQ13
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO and writer
  // ----------------------------------------------------------------
  pixel_fifo #(.WIDTH(32), .DEPTH(`VC_FIFO_DEPTH)) outFifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .inValid(state == ST_PROC && emit),
    .inReady(fifoInReady),
    .inData({row, outCnt, pixOut}),
    .outValid(fifoOutValid),
    .outReady(!wrReq),
    .outData(fifoOut)
  );

  wire [31:0] outAddr = dstBase + 32'(fifoOut[31:20] * stride[31:16]) +
    {18'h0, fifoOut[19:8], 2'b00};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrReq <= 1'b0;
      wrAddr <= 32'h0;
      wrData <= 32'h0;
    end else if (!wrReq && fifoOutValid) begin
      wrReq <= 1'b1; // RQ9
      wrAddr <= outAddr;
      wrData <= {24'h0, fifoOut[7:0]};
    end else if (wrAck) begin
      wrReq <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_stepRange;
    hStep >= `VC_N_MIN && hStep <= `VC_N_MAX &&
      vStep >= `VC_N_MIN && vStep <= `VC_N_MAX;
  endproperty
  a_stepRange: assert property (p_stepRange) // RQ1
    else $error("scale step out of range");
  property p_indepRatio;
    apbWr && paddr == `VC_VRATIO |=> $stable(hRatio);
  endproperty
  a_indepRatio: assert property (p_indepRatio) // RQ2
    else $error("vertical write disturbed horizontal ratio");
  property p_chromaBypass;
    state == ST_RD && rdAck && ctrl[`VC_CTRL_CHROMA] |=> g[0] == $past(win[3]);
  endproperty
  a_chromaBypass: assert property (p_chromaBypass) // RQ3
    else $error("chroma went through the luma filter");
  property p_interp;
    push && isScale && hFrac == 8'h00 |-> pixOut == g[2];
  endproperty
  a_interp: assert property (p_interp) // RQ4
    else $error("integer phase did not pick centre sample");
  property p_clip;
    push |-> outCnt < outW;
  endproperty
  a_clip: assert property (p_clip) // RQ5
    else $error("pixel written beyond clip width");
  property p_field;
    state == ST_RD && isScale && ilace |-> physLine[0] == ctrl[`VC_CTRL_FIELD];
  endproperty
  a_field: assert property (p_field) // RQ6
    else $error("interlaced read from the opposite field");
  property p_chromaUp;
    mode == MODE_CHROMA && ctrl[`VC_CTRL_UP] |-> physLine == row >> 1;
  endproperty
  a_chromaUp: assert property (p_chromaUp) // RQ7
    else $error("4:2:0 line not repeated");
  property p_overlay;
    push && mode == MODE_OVERLAY && code == 2'h0 |-> pixOut == win[0];
  endproperty
  a_overlay: assert property (p_overlay) // RQ8
    else $error("transparent code altered video");
  property p_bitmapFirst;
    state == ST_BMP && rdAck |=> state == ST_RD && rdReq;
  endproperty
  a_bitmapFirst: assert property (p_bitmapFirst) // RQ9
    else $error("video read did not follow bitmap read");
  property p_padRange;
    state == ST_RD && mode == MODE_PAD && srcW != 12'h000 |-> padCol < srcW;
  endproperty
  a_padRange: assert property (p_padRange) // RQ10
    else $error("padding column outside source");
  property p_padField;
    mode == MODE_PAD && ilace && row < {4'h0, padSize[23:16]} &&
      srcH > 12'h001 |-> padLine <= 12'h001;
  endproperty
  a_padField: assert property (p_padField) // RQ11
    else $error("interlaced top pad left its field edge");
  property p_progressive;
    isScale && !ilace |-> physLine == vIdx;
  endproperty
  a_progressive: assert property (p_progressive) // RQ12
    else $error("progressive scaling skipped frame lines");
  property p_done;
    $rose(done) |-> $past(state) == ST_DRAIN && !$past(fifoOutValid) &&
      !$past(wrReq);
  endproperty
  a_done: assert property (p_done) // RQ13
    else $error("done raised before last write");
endmodule : video_conversion_engine
`default_nettype wire

// *** verification/sdram_model.sv ***
// Memory model answering the engine's pixel reads and writes
`timescale 1ns/1ps
`default_nettype none
module sdram_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic rdReq,
  input wire logic [31:0] rdAddr,
  output logic rdAck,
  output logic [31:0] rdData,
  input wire logic wrReq,
  input wire logic [31:0] wrAddr,
  input wire logic [31:0] wrData,
  output logic wrAck,
  input wire logic [3:0] wrDelay
);
  logic [31:0] wmem [logic [31:0]];
  int nWr = 0;
  int rdOdd = 0;
  int rdEven = 0;
  int rdBmp = 0;
  logic [3:0] rdCnt;
  logic [3:0] wrCnt;
  // Source words carry row*16+col, so a wrong fetch shows in the data;
  // between answers the data toggles so stale values cannot pass
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdAck <= 1'b0;
      rdData <= 32'h0;
      rdCnt <= 4'h0;
    end else if (rdReq && !rdAck && rdCnt == 4'h2) begin
      rdAck <= 1'b1;
      rdData <= rdAddr[20] ? 32'h0000_00E4 : {24'h0, rdAddr[9:2]};
      rdCnt <= 4'h0;
      if (rdAddr[20]) rdBmp++;
      else if (rdAddr[6]) rdOdd++;
      else rdEven++;
    end else begin
      rdAck <= 1'b0;
      rdData <= ~rdData;
      rdCnt <= (rdReq && !rdAck) ? rdCnt + 4'h1 : 4'h0;
    end
  end
  // Write latency is set by the bench to stall the output FIFO
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrAck <= 1'b0;
      wrCnt <= 4'h0;
    end else if (wrReq && !wrAck && wrCnt >= wrDelay) begin
      wrAck <= 1'b1;
      wmem[wrAddr] = wrData;
      nWr++;
      wrCnt <= 4'h0;
    end else begin
      wrAck <= 1'b0;
      wrCnt <= (wrReq && !wrAck) ? wrCnt + 4'h1 : 4'h0;
    end
  end
endmodule : sdram_model
`default_nettype wire

// *** verification/video_conversion_engine_bench.sv ***
// Self-checking bench for the video conversion engine
`timescale 1ns/1ps
`default_nettype none
`include "video_conversion_map.svh"
module video_conversion_engine_bench;
  localparam logic [31:0] SRC = 32'h0000_1000;
  localparam logic [31:0] BMP = 32'h0010_0000;
  localparam logic [31:0] DST = 32'h0020_0000;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdAddr, rdData, wrAddr, wrData, rdq;
  logic pready, pslverr, rdReq, rdAck, wrReq, wrAck, err;
  logic [3:0] wrDelay = 4'h0;
  int n_fail = 0;
  int comparisons = 0;
  int n0, o0;
  always #25 sys_clk = ~sys_clk;
  video_conversion_engine DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData),
    .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData), .wrAck(wrAck));
  sdram_model mem (.sys_clk(sys_clk), .rst_b(rst_b), .rdReq(rdReq),
    .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData), .wrReq(wrReq),
    .wrAddr(wrAddr), .wrData(wrData), .wrAck(wrAck), .wrDelay(wrDelay));
  // ----------------------------------------
  // Bus tasks, expected values and result checks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdq = prdata;
    err = pslverr;
    if (n >= 20) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic cfg(input int sw, input int sh, input int ow, input int oh);
    wr(`VC_SRC_ADDR, SRC);
    wr(`VC_DST_ADDR, DST);
    wr(`VC_BMP_ADDR, BMP);
    wr(`VC_SRC_SIZE, 32'(sh << 16 | sw));
    wr(`VC_OUT_SIZE, 32'(oh << 16 | ow));
    wr(`VC_STRIDE, 32'h0040_0040);
  endtask : cfg
  // Starts a picture, sees busy, waits for done and clears it
  task automatic run(input logic [31:0] ctrl);
    int n;
    n = 0;
    wr(`VC_CTRL, ctrl | 32'h1);
    rd(`VC_STATUS);
    check(rdq & 32'h3, 32'h1);
    do begin
      rd(`VC_STATUS);
      n++;
    end while (rdq[1] !== 1'b1 && n < 3000);
    check(rdq & 32'h3, 32'h2);
    wr(`VC_STATUS, 32'h2);
    rd(`VC_STATUS);
    check(rdq, 32'h0);
  endtask : run
  function automatic logic [31:0] px(input int r, input int c);
    return 32'(r * 16 + c);
  endfunction : px
  task automatic pix(input int r, input int c, input logic [31:0] exp);
    check(mem.wmem[DST + 32'(r * 64 + c * 4)], exp);
  endtask : pix
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(`VC_CTRL);
    check(rdq, 32'h0);
    rd(`VC_STATUS);
    check(rdq, 32'h0);
    rd(`VC_HRATIO);
    check(rdq, `VC_RATIO_RST);
    rd(`VC_VRATIO);
    check(rdq, `VC_RATIO_RST);
    rd(12'h030);
    check({rdq[30:0], err}, 32'h1);
    $display("Test registers done");
    wr(`VC_HRATIO, 32'h0FF);
    rd(`VC_HRATIO);
    check(rdq, 32'h100);
    wr(`VC_HRATIO, 32'h801);
    rd(`VC_HRATIO);
    check(rdq, 32'h800);
    wr(`VC_VRATIO, 32'h200);
    rd(`VC_VRATIO);
    check(rdq, 32'h200);
    rd(`VC_HRATIO);
    check(rdq, 32'h800);
    $display("Test ratios done");
    // Slow writes back pixels up in the output FIFO; eight pixels are too few to fill it
    wrDelay <= 4'hA;
    cfg(4, 2, 4, 2);
    wr(`VC_PALETTE, 32'h0033_2211);
    n0 = mem.nWr;
    o0 = mem.rdBmp;
    run(32'h4);
    check(32'(mem.nWr - n0), 32'h8);
    check(32'(mem.rdBmp > o0), 32'h1);
    for (int r = 0; r < 2; r++) begin
      pix(r, 0, px(r, 0));
      pix(r, 1, (px(r, 1) + 32'h11) >> 1);
      pix(r, 2, (px(r, 2) + 32'h22) >> 1);
      pix(r, 3, 32'h33);
    end
    $display("Test overlay done");
    wrDelay <= 4'h0;
    for (int up = 0; up < 2; up++) begin
      cfg(4, up ? 2 : 4, 4, up ? 4 : 2);
      run(up ? 32'h62 : 32'h22);
      for (int r = 0; r < (up ? 4 : 2); r++)
        for (int c = 0; c < 4; c++)
          pix(r, c, px(up ? r / 2 : 2 * r, c));
    end
    $display("Test chroma done");
    wr(`VC_HRATIO, 32'h100);
    cfg(16, 4, 4, 4);
    n0 = mem.nWr;
    o0 = mem.rdOdd;
    run(32'h0);
    check(32'(mem.nWr - n0), 32'h8);
    check(32'(mem.rdOdd - o0), 32'h0);
    wr(`VC_HRATIO, 32'h200);
    wr(`VC_VRATIO, 32'h100);
    cfg(16, 2, 8, 2);
    n0 = mem.nWr;
    o0 = mem.rdEven;
    run(32'h18);
    check(32'(mem.nWr - n0), 32'hA);
    check(32'(mem.rdEven - o0), 32'h0);
    $display("Test scaling done");
    // Pad pictures are large enough for slow writes to fill the FIFO
    wrDelay <= 4'hF;
    cfg(4, 2, 8, 4);
    wr(`VC_PAD, 32'h0001_0002);
    run(32'h6);
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 8; c++)
        pix(r, c, px(r < 1 ? 0 : (r > 2 ? 1 : r - 1),
                     c < 2 ? 0 : (c > 5 ? 3 : c - 2)));
    // Interlaced padding keeps each output row in its own field
    cfg(4, 4, 4, 8);
    wr(`VC_PAD, 32'h0002_0000);
    run(32'hE);
    for (int r = 0; r < 8; r++)
      for (int c = 0; c < 4; c++)
        pix(r, c, px(r < 2 ? r : (r > 5 ? r - 4 : r - 2), c));
    $display("Test padding done");
    complete_run();
  end
endmodule : video_conversion_engine_bench
`default_nettype wire
